//--- design/gsi_top.sv
// Global interrupt aggregation, global status, latched status and pin function logic.
`timescale 1ns/10ps

// Functional notes
// - Pin 3 select: 00 input, 01 port 2 A status, 10 low, 11 high.
// - Pin 2 select: 00 input, 01 port 1 B, 10 low, 11 high; if 8k output off.
// - Pin 1 select: 00 input, 01 port 1 A status, 10 low, 11 high.
// - Port summary bits 7..4 set while any bit of that port's status is set.
// - Interrupt asserts low when a port summary bit and its enable are both set.
// - Global summary bit 0 set when any latched bit is set and enabled.
// - Interrupt asserts low when global summary and its enable are both set.
// - Live bit 1 reads one while any adapter PLL is unlocked.
// - Live bit 0 is AND of globally updated ports' done flags, gated by request.
// - Latched bit 4 sets on pin 4 reference activity, only with input select set.
// - Latched bit 3 sets on activity of the adapter reference clock pin.
// - Latched bit 2 sets once per second and feeds the global summary if enabled.
// - Latched bit 1 sets on rising lock loss; feeds the global summary if enabled.
// - Latched bit 0 sets on rising update done; feeds the global summary if enabled.
// - Latched enables: bit 2 one second, bit 1 lock loss, bit 0 update done.
// - Pin readback bits 7..0 return the level of all eight pins.
// - Latched bits clear by write when clear-on-read is 0, by read when 1.
// - Idle interrupt pin floats when idle drive is 0, drives high when 1.
module gsi_top
  import gsi_pkg::*;
#(
  parameter int ONE_SEC_CYCLES = ONE_SECOND_CYCLES
)
(
  // Clock, reset and freeze
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire gsi_bus_req_t bus_req,
  output logic [DATA_W-1:0] rdata,
  // Per-port summaries and update handshake
  input wire logic [NUM_PORTS-1:0] port_irq_summary,
  input wire logic [NUM_PORTS-1:0] port_update_done,
  input wire logic [NUM_PORTS-1:0] port_update_source_mode,
  // Port status sources for the pins
  input wire logic port1_status_a,
  input wire logic port1_status_b,
  input wire logic port2_status_a,
  input wire logic ref8k_out,
  // Clock rate adapter
  input wire logic [NUM_PLLS-1:0] adapter_pll_locked,
  input wire logic adapter_reference_clock_pin,
  // General-purpose pins
  input wire logic [NUM_PINS-1:0] gpio_in,
  output gsi_pin_drive_t gpio_drive,
  // Interrupt pin, active low
  output logic irq_n_out,
  output logic irq_n_oe
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic irq_idle_drive_r;
  logic update_request_r;
  logic clear_on_read_r;
  logic ref8k_output_select_r;
  logic ref8k_input_select_r;
  logic [NUM_SEL_PINS*SEL_W-1:0] pin_func_r;
  logic [NUM_PORTS-1:0] port_irq_enable_r;
  logic global_latched_summary_enable_r;
  logic [LAT_EN_W-1:0] latched_enable_r;
  logic [LAT_W-1:0] latched_r;
  logic [LAT_W-1:0] latched_nxt;
  logic ref8k_prev_r;
  logic adapter_ref_prev_r;
  logic lock_lost_prev_r;
  logic update_done_prev_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_cnt_nxt;
  logic [NUM_PINS-1:0] pin_level_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic irq_out_r;
  logic irq_oe_r;
  gsi_pin_drive_t pin_drive_r;
  gsi_pin_drive_t pin_drive_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic wr_ctrl1 = bus_req.wr && (bus_req.addr == OFS_CTRL1);
  wire logic wr_ctrl2 = bus_req.wr && (bus_req.addr == OFS_CTRL2);
  wire logic wr_pin_func = bus_req.wr && (bus_req.addr == OFS_PIN_FUNC);
  wire logic wr_sum_en = bus_req.wr && (bus_req.addr == OFS_IRQ_SUM_EN);
  wire logic wr_lat_en = bus_req.wr && (bus_req.addr == OFS_LATCHED_EN);
  wire logic wr_latched = bus_req.wr && (bus_req.addr == OFS_LATCHED);
  wire logic rd_latched = bus_req.rd && (bus_req.addr == OFS_LATCHED);

  // ----------------------------------------------------------------
  // Live status
  // ----------------------------------------------------------------
  wire logic lock_lost = ~(&adapter_pll_locked);
  // Ports in local update mode count as done, so only global ports gate the AND.
  wire logic [NUM_PORTS-1:0] done_or_local = port_update_done | ~port_update_source_mode;
  wire logic update_done = update_request_r && (&done_or_local);

  // ----------------------------------------------------------------
  // Latched status events
  // ----------------------------------------------------------------
  wire logic tick_wrap = (tick_cnt_r == TICK_W'(ONE_SEC_CYCLES - 1));
  assign tick_cnt_nxt = tick_wrap ? '0 : tick_cnt_r + TICK_W'(1);

  wire logic ev_ref8k = ref8k_input_select_r && (gpio_in[REF8K_PIN] != ref8k_prev_r);
  wire logic ev_adapter = adapter_reference_clock_pin != adapter_ref_prev_r;
  wire logic ev_lock_lost = lock_lost && !lock_lost_prev_r;
  wire logic ev_update_done = update_done && !update_done_prev_r;

  wire logic [LAT_W-1:0] lat_events = {ev_ref8k, ev_adapter, tick_wrap, ev_lock_lost,
                                       ev_update_done};

  // Read-clear drops only the bits the read returned; write-clear is write one to clear.
  wire logic [LAT_W-1:0] clr_by_read = (rd_latched && clear_on_read_r) ? latched_r : '0;
  wire logic [LAT_W-1:0] clr_by_write = (wr_latched && !clear_on_read_r) ?
                                        bus_req.wdata[LAT_W-1:0] : '0;
  wire logic [LAT_W-1:0] lat_clear = clr_by_read | clr_by_write;
  assign latched_nxt = (latched_r & ~lat_clear) | lat_events;

  // ----------------------------------------------------------------
  // Interrupt summary
  // ----------------------------------------------------------------
  wire logic global_latched_summary = |(latched_r[LAT_EN_W-1:0] & latched_enable_r);
  wire logic [DATA_W-1:0] irq_sum_word = {8'h00, port_irq_summary, 3'h0,
                                          global_latched_summary};
  wire logic port_irq = |(port_irq_summary & port_irq_enable_r);
  wire logic global_irq = global_latched_summary && global_latched_summary_enable_r;
  wire logic irq_active = port_irq || global_irq;

  // ----------------------------------------------------------------
  // Pin function selection
  // ----------------------------------------------------------------
  wire logic [NUM_SEL_PINS-1:0] pin_status = {port2_status_a, port1_status_b,
                                              port1_status_a};

  always_comb
  begin
    pin_drive_nxt = '0;
    for (int i = 0; i < NUM_SEL_PINS; i++)
    begin
      case (pin_func_r[i*SEL_W +: SEL_W])
        PIN_SEL_STATUS:
        begin
          pin_drive_nxt.out[i] = pin_status[i];
          pin_drive_nxt.oe[i] = 1'b1;
        end
        PIN_SEL_LOW:
        begin
          pin_drive_nxt.out[i] = 1'b0;
          pin_drive_nxt.oe[i] = 1'b1;
        end
        PIN_SEL_HIGH:
        begin
          pin_drive_nxt.out[i] = 1'b1;
          pin_drive_nxt.oe[i] = 1'b1;
        end
        default:
        begin
          pin_drive_nxt.out[i] = 1'b0;
          pin_drive_nxt.oe[i] = 1'b0;
        end
      endcase
    end
    // The reference output takes pin 2 over whatever its select says.
    if (ref8k_output_select_r)
    begin
      pin_drive_nxt.out[1] = ref8k_out;
      pin_drive_nxt.oe[1] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = '0;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        OFS_CTRL1:
        begin
          rdata_nxt[CTRL1_IDLE_DRIVE] = irq_idle_drive_r;
          rdata_nxt[CTRL1_UPDATE_REQ] = update_request_r;
          rdata_nxt[CTRL1_CLEAR_ON_READ] = clear_on_read_r;
        end
        OFS_CTRL2:
        begin
          rdata_nxt[CTRL2_REF8K_OUT_SEL] = ref8k_output_select_r;
          rdata_nxt[CTRL2_REF8K_IN_SEL] = ref8k_input_select_r;
        end
        OFS_PIN_FUNC: rdata_nxt[NUM_SEL_PINS*SEL_W-1:0] = pin_func_r;
        OFS_IRQ_SUM: rdata_nxt = irq_sum_word;
        OFS_IRQ_SUM_EN:
        begin
          rdata_nxt[SUM_PORT_LSB +: NUM_PORTS] = port_irq_enable_r;
          rdata_nxt[SUM_GLOBAL] = global_latched_summary_enable_r;
        end
        OFS_LIVE:
        begin
          rdata_nxt[LIVE_LOCK_LOST] = lock_lost;
          rdata_nxt[LIVE_UPDATE_DONE] = update_done;
        end
        OFS_LATCHED: rdata_nxt[LAT_W-1:0] = latched_r;
        OFS_LATCHED_EN: rdata_nxt[LAT_EN_W-1:0] = latched_enable_r;
        OFS_PIN_LEVEL: rdata_nxt[NUM_PINS-1:0] = pin_level_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_idle_drive_r <= REG_RESET[CTRL1_IDLE_DRIVE];
      update_request_r <= REG_RESET[CTRL1_UPDATE_REQ];
      clear_on_read_r <= REG_RESET[CTRL1_CLEAR_ON_READ];
      ref8k_output_select_r <= REG_RESET[CTRL2_REF8K_OUT_SEL];
      ref8k_input_select_r <= REG_RESET[CTRL2_REF8K_IN_SEL];
      pin_func_r <= REG_RESET[NUM_SEL_PINS*SEL_W-1:0];
      port_irq_enable_r <= REG_RESET[SUM_PORT_LSB +: NUM_PORTS];
      global_latched_summary_enable_r <= REG_RESET[SUM_GLOBAL];
      latched_enable_r <= REG_RESET[LAT_EN_W-1:0];
    end
    else if (ce)
    begin
      if (wr_ctrl1)
      begin
        irq_idle_drive_r <= bus_req.wdata[CTRL1_IDLE_DRIVE];
        update_request_r <= bus_req.wdata[CTRL1_UPDATE_REQ];
        clear_on_read_r <= bus_req.wdata[CTRL1_CLEAR_ON_READ];
      end
      if (wr_ctrl2)
      begin
        ref8k_output_select_r <= bus_req.wdata[CTRL2_REF8K_OUT_SEL];
        ref8k_input_select_r <= bus_req.wdata[CTRL2_REF8K_IN_SEL];
      end
      if (wr_pin_func)
      begin
        pin_func_r <= bus_req.wdata[NUM_SEL_PINS*SEL_W-1:0];
      end
      if (wr_sum_en)
      begin
        port_irq_enable_r <= bus_req.wdata[SUM_PORT_LSB +: NUM_PORTS];
        global_latched_summary_enable_r <= bus_req.wdata[SUM_GLOBAL];
      end
      if (wr_lat_en)
      begin
        latched_enable_r <= bus_req.wdata[LAT_EN_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, edge history and tick counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      latched_r <= '0;
      ref8k_prev_r <= 1'b0;
      adapter_ref_prev_r <= 1'b0;
      lock_lost_prev_r <= 1'b0;
      update_done_prev_r <= 1'b0;
      tick_cnt_r <= '0;
      pin_level_r <= '0;
    end
    else if (ce)
    begin
      latched_r <= latched_nxt;
      ref8k_prev_r <= gpio_in[REF8K_PIN];
      adapter_ref_prev_r <= adapter_reference_clock_pin;
      lock_lost_prev_r <= lock_lost;
      update_done_prev_r <= update_done;
      tick_cnt_r <= tick_cnt_nxt;
      pin_level_r <= gpio_in;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_r <= '0;
      irq_out_r <= 1'b1;
      irq_oe_r <= 1'b0;
      pin_drive_r <= '0;
    end
    else if (ce)
    begin
      rdata_r <= rdata_nxt;
      irq_out_r <= !irq_active;
      irq_oe_r <= irq_active || irq_idle_drive_r;
      pin_drive_r <= pin_drive_nxt;
    end
  end

  assign rdata = rdata_r;
  assign irq_n_out = irq_out_r;
  assign irq_n_oe = irq_oe_r;
  assign gpio_drive = pin_drive_r;

endmodule

//--- design/gsi_pkg.sv
// Shared constants and types for the global interrupt, status and pin block.
package gsi_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int NUM_PORTS = 4;
  localparam int NUM_PLLS = 3;
  localparam int NUM_PINS = 8;
  localparam int NUM_SEL_PINS = 3;
  localparam int SEL_W = 2;
  localparam int LAT_W = 5;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 12'h002;
  localparam logic [ADDR_W-1:0] OFS_CTRL2 = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PIN_FUNC = 12'h00a;
  localparam logic [ADDR_W-1:0] OFS_IRQ_SUM = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IRQ_SUM_EN = 12'h012;
  localparam logic [ADDR_W-1:0] OFS_LIVE = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_LATCHED = 12'h016;
  localparam logic [ADDR_W-1:0] OFS_LATCHED_EN = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 12'h01c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL1_IDLE_DRIVE = 14;
  localparam int CTRL1_UPDATE_REQ = 3;
  localparam int CTRL1_CLEAR_ON_READ = 2;
  localparam int CTRL2_REF8K_OUT_SEL = 9;
  localparam int CTRL2_REF8K_IN_SEL = 8;
  localparam int SUM_PORT_LSB = 4;
  localparam int SUM_GLOBAL = 0;
  localparam int LIVE_LOCK_LOST = 1;
  localparam int LIVE_UPDATE_DONE = 0;
  localparam int LAT_REF8K = 4;
  localparam int LAT_ADAPTER_REF = 3;
  localparam int LAT_ONE_SECOND = 2;
  localparam int LAT_LOCK_LOST = 1;
  localparam int LAT_UPDATE_DONE = 0;
  localparam int LAT_EN_W = 3;
  localparam int REF8K_PIN = 3;

  // ----------------------------------------------------------------
  // Pin function codes and reset values
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] PIN_SEL_INPUT = 2'h0;
  localparam logic [SEL_W-1:0] PIN_SEL_STATUS = 2'h1;
  localparam logic [SEL_W-1:0] PIN_SEL_LOW = 2'h2;
  localparam logic [SEL_W-1:0] PIN_SEL_HIGH = 2'h3;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_PS = 25000;
  localparam longint ONE_SECOND_MS = 1000;
  localparam int ONE_SECOND_CYCLES = int'((ONE_SECOND_MS * 1000000000) / CLK_PERIOD_PS);
  localparam int TICK_W = 26;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gsi_bus_req_t;

  typedef struct packed {
    logic [NUM_SEL_PINS-1:0] out;
    logic [NUM_SEL_PINS-1:0] oe;
  } gsi_pin_drive_t;

endpackage

//--- testbench/gsi_checker.sv
// Port-level assertions for the global interrupt, status and pin block.
`timescale 1ns/10ps
module gsi_checker
  import gsi_pkg::*;
#(
  parameter int ONE_SEC_CYCLES = 50
)
(
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire gsi_bus_req_t bus_req,
  input wire logic [DATA_W-1:0] rdata,
  // Status sources
  input wire logic [NUM_PORTS-1:0] port_irq_summary,
  input wire logic [NUM_PORTS-1:0] port_update_done,
  input wire logic [NUM_PORTS-1:0] port_update_source_mode,
  input wire logic port1_status_a,
  input wire logic port1_status_b,
  input wire logic port2_status_a,
  input wire logic ref8k_out,
  input wire logic [NUM_PLLS-1:0] adapter_pll_locked,
  input wire logic adapter_reference_clock_pin,
  // Pins
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire gsi_pin_drive_t gpio_drive,
  input wire logic irq_n_out,
  input wire logic irq_n_oe
);
  // ----------------------------------------------------------------
  // Shadow of the writable controls, rebuilt from bus writes
  // ----------------------------------------------------------------
  logic [5:0] sel_r;
  logic outsel_r;
  logic idle_r;
  logic req_r;
  logic [7:0] en_r;
  logic [2:0] exp_out;
  logic [2:0] exp_oe;
  wire wr_ok = ce && bus_req.wr;
  wire [2:0] stat = {port2_status_a, port1_status_b, port1_status_a};
  wire port_hit = |(port_irq_summary & en_r[7:4]);
  wire upd_done = req_r && (&(port_update_done | ~port_update_source_mode));
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_r <= 6'h00;
      outsel_r <= 1'b0;
      idle_r <= 1'b0;
      req_r <= 1'b0;
      en_r <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (bus_req.addr == OFS_PIN_FUNC) sel_r <= bus_req.wdata[5:0];
      if (bus_req.addr == OFS_CTRL2) outsel_r <= bus_req.wdata[CTRL2_REF8K_OUT_SEL];
      if (bus_req.addr == OFS_CTRL1) idle_r <= bus_req.wdata[CTRL1_IDLE_DRIVE];
      if (bus_req.addr == OFS_CTRL1) req_r <= bus_req.wdata[CTRL1_UPDATE_REQ];
      if (bus_req.addr == OFS_IRQ_SUM_EN) en_r <= bus_req.wdata[7:0];
    end
  end
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      exp_oe[i] = sel_r[2*i+:2] != PIN_SEL_INPUT;
      exp_out[i] = (sel_r[2*i+:2] == PIN_SEL_STATUS) ? stat[i] : (sel_r[2*i+:2] == PIN_SEL_HIGH);
    end
    if (outsel_r)
    begin
      exp_oe[1] = 1'b1;
      exp_out[1] = ref8k_out;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_pin_function_map: assert property ($past(ce) |-> gpio_drive.oe == $past(exp_oe) &&
    (gpio_drive.out & gpio_drive.oe) == ($past(exp_out) & $past(exp_oe)))
    else $error("pin drive differs from select");
  a_irq_port_path: assert property ($past(ce) && $past(port_hit) |-> !irq_n_out && irq_n_oe)
    else $error("enabled port summary did not pull interrupt low");
  a_irq_quiet: assert property ($past(ce) && !$past(port_hit) && !$past(en_r[0]) |-> irq_n_out)
    else $error("interrupt low with no enabled cause");
  a_irq_idle_drive: assert property ($past(ce) && irq_n_out |-> irq_n_oe == $past(idle_r))
    else $error("idle interrupt pin drive wrong");
  a_irq_active_drives: assert property (!irq_n_out |-> irq_n_oe)
    else $error("active interrupt not driven");
  a_rdata_idle_zero: assert property ($past(ce) && !$past(bus_req.rd) |-> rdata == REG_RESET)
    else $error("read data not zero outside read answer");
  a_live_status: assert property ($past(ce && bus_req.rd && bus_req.addr == OFS_LIVE) |->
    rdata == {14'h0000, $past(~&adapter_pll_locked), $past(upd_done)})
    else $error("live status read wrong");
  a_enable_readback: assert property ($past(ce && bus_req.rd && bus_req.addr == OFS_IRQ_SUM_EN)
    |-> rdata == {8'h00, $past(en_r) & 8'hf1})
    else $error("summary enable read wrong");
  a_summary_ports: assert property ($past(ce && bus_req.rd && bus_req.addr == OFS_IRQ_SUM) &&
    $past(port_irq_summary, 2) == $past(port_irq_summary) |-> rdata[7:4] == $past(port_irq_summary))
    else $error("port summary bits wrong");
  c_irq_port: cover property (port_hit ##1 !irq_n_out);
  c_irq_global: cover property (!port_hit && en_r[0] ##1 !irq_n_out);
  c_live_read: cover property (bus_req.rd && bus_req.addr == OFS_LIVE && upd_done);
  c_pin_status: cover property (sel_r == 6'h15);
endmodule

bind gsi_top gsi_checker #(.ONE_SEC_CYCLES(ONE_SEC_CYCLES)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .ce(ce), .bus_req(bus_req), .rdata(rdata), .port_irq_summary(port_irq_summary),
  .port_update_done(port_update_done), .port_update_source_mode(port_update_source_mode),
  .port1_status_a(port1_status_a), .port1_status_b(port1_status_b),
  .port2_status_a(port2_status_a), .ref8k_out(ref8k_out), .adapter_pll_locked(adapter_pll_locked),
  .adapter_reference_clock_pin(adapter_reference_clock_pin), .gpio_in(gpio_in),
  .gpio_drive(gpio_drive), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

//--- testbench/global_irq_status_gpio_bench.sv
// Self-checking bench for the global interrupt, status and pin block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module global_irq_status_gpio_bench
  import gsi_pkg::*;
;
  typedef struct packed {
    logic [5:0] sel;
    logic os;
    logic [2:0] st;
    logic rf;
    logic [2:0] out;
    logic [2:0] oe;
  } gsi_row_t;
  // Each row: selects, output select, status sources, reference, expected drive.
  gsi_row_t rows [9] = '{'{6'h00, 1'b0, 3'h7, 1'b0, 3'h0, 3'h0}, '{6'h15, 1'b0, 3'h5, 1'b0, 3'h5, 3'h7},
    '{6'h15, 1'b0, 3'h2, 1'b0, 3'h2, 3'h7}, '{6'h2a, 1'b0, 3'h7, 1'b0, 3'h0, 3'h7},
    '{6'h3f, 1'b0, 3'h0, 1'b0, 3'h7, 3'h7}, '{6'h32, 1'b0, 3'h7, 1'b0, 3'h4, 3'h5},
    '{6'h2d, 1'b0, 3'h1, 1'b0, 3'h3, 3'h7}, '{6'h08, 1'b1, 3'h0, 1'b1, 3'h2, 3'h2},
    '{6'h3f, 1'b1, 3'h0, 1'b0, 3'h5, 3'h7}};
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  gsi_bus_req_t bus_req = '0;
  logic [DATA_W-1:0] rdata;
  logic [3:0] port_irq_summary = 4'h0;
  logic [3:0] port_update_done = 4'h0;
  logic [3:0] port_update_source_mode = 4'h0;
  logic [2:0] stat = 3'h0;
  logic ref8k_out = 1'b0;
  logic [2:0] adapter_pll_locked = 3'h7;
  logic adapter_clk = 1'b0;
  logic [7:0] pad = 8'h00;
  gsi_pin_drive_t gpio_drive;
  logic irq_n_out;
  logic irq_n_oe;
  int n_fail = 0;
  int n_compared = 0;
  // The pads of pins 1 to 3 follow the block whenever it drives them.
  wire [7:0] gpio_lvl = {pad[7:3], (gpio_drive.out & gpio_drive.oe) | (pad[2:0] & ~gpio_drive.oe)};
  always #12.5 clk_sys = ~clk_sys;
  gsi_top #(.ONE_SEC_CYCLES(50)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .bus_req(bus_req), .rdata(rdata), .port_irq_summary(port_irq_summary),
    .port_update_done(port_update_done), .port_update_source_mode(port_update_source_mode),
    .port1_status_a(stat[0]), .port1_status_b(stat[1]), .port2_status_a(stat[2]),
    .ref8k_out(ref8k_out), .adapter_pll_locked(adapter_pll_locked),
    .adapter_reference_clock_pin(adapter_clk), .gpio_in(gpio_lvl), .gpio_drive(gpio_drive),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask
  task automatic chk_rd(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
    input logic [DATA_W-1:0] m);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    `CHK(nm, e & m, rdata & m)
  endtask
  task automatic toggle(input logic both);
    repeat (4)
    begin
      @(posedge clk_sys);
      adapter_clk <= ~adapter_clk ^ both;
      pad[REF8K_PIN] <= ~pad[REF8K_PIN];
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #(25 * 6000);
    n_fail++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(3);
    `CHK("irq_reset", 2'b10, {irq_n_out, irq_n_oe})
    rst_b <= 1'b1;
    chk_rd("sum_en_rst", OFS_IRQ_SUM_EN, 16'h0000, 16'hffff);
    chk_rd("lat_en_rst", OFS_LATCHED_EN, 16'h0000, 16'hffff);
    chk_rd("lat_rst", OFS_LATCHED, 16'h0000, 16'hffff);
    bus_wr(OFS_IRQ_SUM, 16'hffff);
    chk_rd("sum_ro", OFS_IRQ_SUM, 16'h0000, 16'hffff);
    chk_rd("unmapped", 12'h01e, 16'h0000, 16'hffff);
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      stat <= rows[i].st;
      ref8k_out <= rows[i].rf;
      bus_wr(OFS_CTRL2, {6'h00, rows[i].os, 9'h000});
      bus_wr(OFS_PIN_FUNC, {10'h000, rows[i].sel});
      tick(2);
      `CHK("pin_oe", rows[i].oe, gpio_drive.oe)
      `CHK("pin_out", rows[i].out, gpio_drive.out & gpio_drive.oe)
      chk_rd("pin_level", OFS_PIN_LEVEL, {13'h0000, rows[i].out & rows[i].oe}, 16'hffff);
    end
    bus_wr(OFS_PIN_FUNC, 16'h0000);
    bus_wr(OFS_CTRL2, 16'h0000);
    bus_wr(OFS_IRQ_SUM_EN, 16'h0010);
    port_irq_summary <= 4'h1;
    tick(3);
    `CHK("irq_port", 2'b01, {irq_n_out, irq_n_oe})
    chk_rd("sum_port", OFS_IRQ_SUM, 16'h0010, 16'hffff);
    port_irq_summary <= 4'he;
    tick(3);
    `CHK("irq_masked", 1'b1, irq_n_out)
    chk_rd("sum_ports", OFS_IRQ_SUM, 16'h00e0, 16'hffff);
    bus_wr(OFS_CTRL1, 16'h4000);
    tick(2);
    `CHK("irq_idle_hi", 2'b11, {irq_n_out, irq_n_oe})
    bus_wr(OFS_CTRL1, 16'h0000);
    port_irq_summary <= 4'h0;
    bus_wr(OFS_LATCHED, 16'h001f);
    adapter_pll_locked <= 3'h6;
    chk_rd("live_lock", OFS_LIVE, 16'h0002, 16'hffff);
    adapter_pll_locked <= 3'h7;
    chk_rd("lat_lock", OFS_LATCHED, 16'h0002, 16'hfffb);
    bus_wr(OFS_LATCHED, 16'h0002);
    chk_rd("lat_wclr", OFS_LATCHED, 16'h0000, 16'hfffb);
    bus_wr(OFS_LATCHED_EN, 16'h0002);
    bus_wr(OFS_IRQ_SUM_EN, 16'h0001);
    adapter_pll_locked <= 3'h3;
    tick(3);
    adapter_pll_locked <= 3'h7;
    chk_rd("sum_global", OFS_IRQ_SUM, 16'h0001, 16'hffff);
    `CHK("irq_global", 1'b0, irq_n_out)
    bus_wr(OFS_LATCHED_EN, 16'h0000);
    chk_rd("sum_gmask", OFS_IRQ_SUM, 16'h0000, 16'hffff);
    tick(2);
    `CHK("irq_gmask", 1'b1, irq_n_out)
    bus_wr(OFS_CTRL1, 16'h0004);
    chk_rd("lat_rd1", OFS_LATCHED, 16'h0002, 16'hfffb);
    chk_rd("lat_rd2", OFS_LATCHED, 16'h0000, 16'hfffb);
    port_update_source_mode <= 4'h3;
    port_update_done <= 4'h1;
    bus_wr(OFS_CTRL1, 16'h0008);
    bus_wr(OFS_LATCHED, 16'h001f);
    chk_rd("live_upd0", OFS_LIVE, 16'h0000, 16'hffff);
    port_update_done <= 4'h3;
    chk_rd("live_upd1", OFS_LIVE, 16'h0001, 16'hffff);
    chk_rd("lat_upd", OFS_LATCHED, 16'h0001, 16'hfffb);
    // Software drops the update request only once update done has read high.
    bus_wr(OFS_CTRL1, 16'h0000);
    chk_rd("live_noreq", OFS_LIVE, 16'h0000, 16'hffff);
    bus_wr(OFS_LATCHED, 16'h001f);
    toggle(1'b0);
    chk_rd("lat_adapter", OFS_LATCHED, 16'h0008, 16'hfffb);
    bus_wr(OFS_CTRL2, 16'h0100);
    bus_wr(OFS_LATCHED, 16'h001f);
    toggle(1'b1);
    chk_rd("lat_ref8k", OFS_LATCHED, 16'h0010, 16'hfffb);
    bus_wr(OFS_LATCHED_EN, 16'h0004);
    bus_wr(OFS_LATCHED, 16'h0004);
    tick(52);
    chk_rd("lat_second", OFS_LATCHED, 16'h0004, 16'h0004);
    chk_rd("sum_second", OFS_IRQ_SUM, 16'h0001, 16'hffff);
    pad <= 8'ha5;
    tick(3);
    chk_rd("pin_pads", OFS_PIN_LEVEL, 16'h00a5, 16'hffff);
    final_report();
  end
endmodule
